// [pkg/aiss_pkg.sv]
// Package: register map, field layout, timing and types for the ADC selection sequencer
package aiss_pkg;
    // Register byte offsets
    localparam logic [11:0] OFF_SELECTION = 12'h000;
    localparam logic [11:0] OFF_CONTROL = 12'h004;
    localparam logic [11:0] OFF_RESULT = 12'h008;
    localparam logic [11:0] OFF_STATUS = 12'h00C;
    localparam logic [11:0] OFF_PRESCALE = 12'h010;
    // Selection register fields
    localparam int SEL_CH_LSB = 0;
    localparam int SEL_REF_LSB = 6;
    // Control register fields
    localparam int CTL_EN_BIT = 0;
    localparam int CTL_START_BIT = 1;
    localparam int CTL_AUTO_BIT = 2;
    localparam int CTL_HSM_BIT = 3;
    localparam int CTL_DONE_BIT = 4;
    localparam int CTL_FREE_BIT = 5;
    // Status register fields
    localparam int STA_BUSY_BIT = 0;
    localparam int STA_FIRST_BIT = 1;
    localparam int STA_LOCK_BIT = 2;
    // Reset values
    localparam logic [7:0] SELECTION_RST = 8'h00;
    localparam logic [7:0] PRESCALE_RST = 8'h01;
    // Conversion lengths in ADC clock cycles
    localparam logic [4:0] NORMAL_CYCLES = 5'h0D;
    localparam logic [4:0] FIRST_CYCLES = 5'h19;
    // Sample-and-hold position in ADC cycles from conversion start
    localparam logic [4:0] SAMPLE_NORMAL_CYC = 5'h01;
    localparam logic [4:0] SAMPLE_FIRST_CYC = 5'h0D;
    // Differential settling time
    localparam int SETTLE_US = 125;
    localparam int CLK_MHZ = 50;
    localparam int SETTLE_CYCLES = SETTLE_US * CLK_MHZ;
    // Reference codes
    typedef enum logic [1:0] {
        AISS_REF_EXT_PIN = 2'b00,
        AISS_REF_SUPPLY = 2'b01,
        AISS_REF_RSVD = 2'b10,
        AISS_REF_INT_256 = 2'b11
    } aiss_ref_t;
    // Active selection to analog mux
    typedef struct packed {
        aiss_ref_t ref_sel;
        logic [4:0] channel;
    } aiss_sel_t;
    typedef enum logic [2:0] {
        AISS_IDLE = 3'b001,
        AISS_WAIT = 3'b010,
        AISS_CONV = 3'b100
    } aiss_state_t;
endpackage : aiss_pkg

// [core/aiss_sequencer.sv]
// ADC control: selection buffering, conversion sequencing and APB registers
`timescale 1ns/1ps
`default_nettype none
module aiss_sequencer #(
    parameter int SETTLE_COUNT = aiss_pkg::SETTLE_CYCLES
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // System events
    input wire logic trigger_event,
    input wire logic sleep_quiet,
    input wire logic cpu_halted,
    // Analog side
    input wire logic [9:0] sar_code,
    output aiss_pkg::aiss_sel_t active_sel,
    output logic sample_hold,
    output logic conv_irq_req,
    output logic settling
);
    ////////////////////////////////////////////////////////////////////////////
    // Registers
    logic [7:0] temp_sel_r;
    logic converter_enable_r;
    logic conversion_start_bit_r;
    logic auto_trigger_enable_r;
    logic high_speed_mode_bit_r;
    logic conversion_done_flag_r;
    logic free_run_r;
    logic [7:0] prescale_r;
    logic [9:0] result_r;
    logic [7:0] presc_cnt_r;
    logic [4:0] cyc_r;
    logic [4:0] conv_len_r;
    logic first_pending_r;
    logic trig_q1_r, trig_q2_r, trig_q3_r;
    logic halted_q_r;
    logic [31:0] settle_r;
    aiss_pkg::aiss_state_t state_r;
    aiss_pkg::aiss_sel_t active_r;

    logic wr_en, rd_en, adc_tick, trig_rise, sleep_start, sw_start, conv_end, last_cycle;
    logic [31:0] rdata;
    logic addr_ok;

    assign wr_en = psel && penable && pwrite;
    assign rd_en = psel && penable && !pwrite;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_ok;

    ////////////////////////////////////////////////////////////////////////////
    // ADC clock prescaler, held reset while disabled
    always_ff @(posedge ref_clk) begin
        if (rst || !converter_enable_r || (auto_trigger_enable_r && trig_rise && state_r == aiss_pkg::AISS_IDLE)) begin
            presc_cnt_r <= 8'h00;
        end else if (presc_cnt_r >= prescale_r) begin
            presc_cnt_r <= 8'h00;
        end else begin
            presc_cnt_r <= presc_cnt_r + 8'h01;
        end
    end
    assign adc_tick = converter_enable_r && (presc_cnt_r >= prescale_r);

    // Trigger pin synchroniser; rise counted when second and third stages agree
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            trig_q1_r <= 1'b0;
            trig_q2_r <= 1'b0;
            trig_q3_r <= 1'b0;
            halted_q_r <= 1'b0;
        end else begin
            trig_q1_r <= trigger_event;
            trig_q2_r <= trig_q1_r;
            trig_q3_r <= trig_q2_r;
            halted_q_r <= cpu_halted;
        end
    end
    logic trig_prev_r;
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            trig_prev_r <= 1'b0;
        end else if (trig_q2_r == trig_q3_r) begin
            trig_prev_r <= trig_q3_r;
        end
    end
    assign trig_rise = (trig_q2_r == trig_q3_r) && trig_q3_r && !trig_prev_r;

    // Noise canceller: halt edge in quiet sleep with ADC ready starts a conversion
    assign sleep_start = sleep_quiet && cpu_halted && !halted_q_r && converter_enable_r
        && !conversion_start_bit_r && !auto_trigger_enable_r;

    ////////////////////////////////////////////////////////////////////////////
    // Conversion sequencer
    assign last_cycle = (state_r == aiss_pkg::AISS_CONV) && (cyc_r == conv_len_r - 5'h01);
    assign conv_end = last_cycle && adc_tick;
    assign sw_start = conversion_start_bit_r || (auto_trigger_enable_r && trig_rise && !conversion_done_flag_r);

    always_ff @(posedge ref_clk) begin
        if (rst || !converter_enable_r) begin
            state_r <= aiss_pkg::AISS_IDLE;
            cyc_r <= 5'h00;
            conv_len_r <= aiss_pkg::NORMAL_CYCLES;
        end else begin
            case (state_r)
                aiss_pkg::AISS_IDLE: begin
                    // A start that meets a tick converts at once; a trigger waits for the reset prescaler
                    if ((sw_start || sleep_start) && adc_tick && !(auto_trigger_enable_r && trig_rise)) begin
                        state_r <= aiss_pkg::AISS_CONV;
                        cyc_r <= 5'h00;
                        conv_len_r <= first_pending_r ? aiss_pkg::FIRST_CYCLES : aiss_pkg::NORMAL_CYCLES;
                    end else if (sw_start || sleep_start) begin
                        state_r <= aiss_pkg::AISS_WAIT;
                    end
                end
                aiss_pkg::AISS_WAIT: begin
                    if (adc_tick) begin
                        state_r <= aiss_pkg::AISS_CONV;
                        cyc_r <= 5'h00;
                        conv_len_r <= first_pending_r ? aiss_pkg::FIRST_CYCLES : aiss_pkg::NORMAL_CYCLES;
                    end
                end
                aiss_pkg::AISS_CONV: begin
                    if (conv_end) begin
                        cyc_r <= 5'h00;
                        conv_len_r <= aiss_pkg::NORMAL_CYCLES;
                        state_r <= (free_run_r && conversion_start_bit_r) ? aiss_pkg::AISS_CONV
                            : aiss_pkg::AISS_IDLE;
                    end else if (adc_tick) begin
                        cyc_r <= cyc_r + 5'h01;
                    end
                end
                default: state_r <= aiss_pkg::AISS_IDLE;
            endcase
        end
    end

    // First conversion after enable is extended
    always_ff @(posedge ref_clk) begin
        if (rst || !converter_enable_r) begin
            first_pending_r <= 1'b1;
        end else if (conv_end) begin
            first_pending_r <= 1'b0;
        end
    end

    // Selection copy: on ADC ticks while unlocked, or in the final cycle
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            active_r <= aiss_pkg::aiss_sel_t'(7'h00);
        end else if (state_r != aiss_pkg::AISS_CONV || last_cycle) begin
            if (adc_tick || !converter_enable_r) begin
                active_r.channel <= temp_sel_r[aiss_pkg::SEL_CH_LSB +: 5];
                active_r.ref_sel <= aiss_pkg::aiss_ref_t'(temp_sel_r[aiss_pkg::SEL_REF_LSB +: 2]);
            end
        end
    end
    assign active_sel = active_r;
    assign sample_hold = (state_r == aiss_pkg::AISS_CONV)
        && (cyc_r == (first_pending_r ? aiss_pkg::SAMPLE_FIRST_CYC : aiss_pkg::SAMPLE_NORMAL_CYC));

    // Settling indicator after channel or reference change, HSM not involved
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            settle_r <= 32'h0;
        end else if (wr_en && paddr == aiss_pkg::OFF_SELECTION && pwdata[7:0] != temp_sel_r) begin
            settle_r <= 32'(SETTLE_COUNT);
        end else if (settle_r != 32'h0) begin
            settle_r <= settle_r - 32'h1;
        end
    end
    assign settling = (settle_r != 32'h0);

    ////////////////////////////////////////////////////////////////////////////
    // Software registers
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            temp_sel_r <= aiss_pkg::SELECTION_RST;
            prescale_r <= aiss_pkg::PRESCALE_RST;
            converter_enable_r <= 1'b0;
            auto_trigger_enable_r <= 1'b0;
            high_speed_mode_bit_r <= 1'b0;
            free_run_r <= 1'b0;
        end else if (wr_en) begin
            if (paddr == aiss_pkg::OFF_SELECTION) begin
                temp_sel_r <= pwdata[7:0];
            end else if (paddr == aiss_pkg::OFF_PRESCALE) begin
                prescale_r <= pwdata[7:0];
            end else if (paddr == aiss_pkg::OFF_CONTROL) begin
                converter_enable_r <= pwdata[aiss_pkg::CTL_EN_BIT];
                auto_trigger_enable_r <= pwdata[aiss_pkg::CTL_AUTO_BIT];
                high_speed_mode_bit_r <= pwdata[aiss_pkg::CTL_HSM_BIT];
                free_run_r <= pwdata[aiss_pkg::CTL_FREE_BIT];
            end
        end
    end

    // Start bit: set by write, cleared at end of single conversion
    always_ff @(posedge ref_clk) begin
        if (rst || !converter_enable_r) begin
            conversion_start_bit_r <= 1'b0;
        end else if (wr_en && paddr == aiss_pkg::OFF_CONTROL && pwdata[aiss_pkg::CTL_START_BIT]) begin
            conversion_start_bit_r <= 1'b1;
        end else if (conv_end && !free_run_r) begin
            conversion_start_bit_r <= 1'b0;
        end else if (state_r == aiss_pkg::AISS_WAIT && adc_tick && !free_run_r) begin
            conversion_start_bit_r <= conversion_start_bit_r;
        end
    end

    // Done flag: set wins over a write-one clear
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            conversion_done_flag_r <= 1'b0;
        end else if (conv_end) begin
            conversion_done_flag_r <= 1'b1;
        end else if (wr_en && paddr == aiss_pkg::OFF_CONTROL && pwdata[aiss_pkg::CTL_DONE_BIT]) begin
            conversion_done_flag_r <= 1'b0;
        end
    end
    assign conv_irq_req = conversion_done_flag_r;

    // Result capture, unsigned code from the SAR
    always_ff @(posedge ref_clk) begin
        if (rst) begin
            result_r <= 10'h000;
        end else if (conv_end) begin
            result_r <= sar_code;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read mux
    always_comb begin
        rdata = 32'h0;
        addr_ok = 1'b1;
        if (paddr == aiss_pkg::OFF_SELECTION) begin
            rdata[7:0] = temp_sel_r;
        end else if (paddr == aiss_pkg::OFF_CONTROL) begin
            rdata[aiss_pkg::CTL_EN_BIT] = converter_enable_r;
            rdata[aiss_pkg::CTL_START_BIT] = conversion_start_bit_r || state_r != aiss_pkg::AISS_IDLE;
            rdata[aiss_pkg::CTL_AUTO_BIT] = auto_trigger_enable_r;
            rdata[aiss_pkg::CTL_HSM_BIT] = high_speed_mode_bit_r;
            rdata[aiss_pkg::CTL_DONE_BIT] = conversion_done_flag_r;
            rdata[aiss_pkg::CTL_FREE_BIT] = free_run_r;
        end else if (paddr == aiss_pkg::OFF_RESULT) begin
            rdata[9:0] = result_r;
        end else if (paddr == aiss_pkg::OFF_STATUS) begin
            rdata[aiss_pkg::STA_BUSY_BIT] = (state_r != aiss_pkg::AISS_IDLE);
            rdata[aiss_pkg::STA_FIRST_BIT] = first_pending_r;
            rdata[aiss_pkg::STA_LOCK_BIT] = (state_r == aiss_pkg::AISS_CONV);
        end else if (paddr == aiss_pkg::OFF_PRESCALE) begin
            rdata[7:0] = prescale_r;
        end else begin
            addr_ok = 1'b0;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst) begin
            prdata <= 32'h0;
        end else if (psel && !penable && !pwrite) begin
            prdata <= rdata;
        end
    end
endmodule : aiss_sequencer
`default_nettype wire

// [tb/aiss_sar_model.sv]
// SAR model: holds the mux selection at sample time and answers with a code built from it
`timescale 1ns/1ps
`default_nettype none
module aiss_sar_model (
    // Clock
    input wire logic ref_clk,
    // Mux side
    input wire aiss_pkg::aiss_sel_t active_sel,
    input wire logic sample_hold,
    output logic [9:0] sar_code
);
    aiss_pkg::aiss_sel_t held_r;
    always_ff @(posedge ref_clk) begin
        if (sample_hold) begin
            held_r <= active_sel;
        end
    end
    // Channel 1F on the internal reference reads as full scale
    assign sar_code = {held_r.channel, held_r.ref_sel, 3'h7};
endmodule : aiss_sar_model
`default_nettype wire

// [tb/aiss_sequencer_chk.sv]
// Checker: bus and sequencing properties at the sequencer ports
`timescale 1ns/1ps
`default_nettype none
module aiss_sequencer_chk #(
    parameter int SETTLE_COUNT = 20
) (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Events and analog side
    input wire logic trigger_event,
    input wire logic sleep_quiet,
    input wire logic cpu_halted,
    input wire logic [9:0] sar_code,
    input wire aiss_pkg::aiss_sel_t active_sel,
    input wire logic sample_hold,
    input wire logic conv_irq_req,
    input wire logic settling
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    logic acc;
    logic mapped;
    logic wr_sel;
    logic [15:0] run_r;
    assign acc = psel && penable;
    assign mapped = paddr[1:0] == 2'h0 && paddr <= 12'h010;
    assign wr_sel = acc && pwrite && paddr == 12'h000;
    // Length of the current settling run
    always_ff @(posedge ref_clk) begin
        if (rst || !settling) begin
            run_r <= 16'h0000;
        end else begin
            run_r <= run_r + 16'h0001;
        end
    end
    chk_ready_high: assert property (pready) else $error("pready low");
    chk_err_unmapped: assert property (acc && !mapped |-> pslverr) else $error("no error on unmapped access");
    chk_err_mapped: assert property (acc && mapped |-> !pslverr) else $error("error on mapped access");
    chk_rd_unmapped: assert property (acc && !pwrite && !mapped |-> prdata == 32'h0000_0000)
        else $error("unmapped read not zero");
    chk_rst_clear: assert property ($fell(rst) |-> active_sel == 7'h00 && !conv_irq_req && !settling)
        else $error("state not cleared by reset");
    chk_sel_frozen: assert property ($rose(sample_hold) |=> $stable(active_sel) [*8])
        else $error("selection moved during conversion");
    chk_done_bound: assert property ($rose(sample_hold) |-> ##[1:120] conv_irq_req)
        else $error("no completion after sampling");
    chk_settle_len: assert property ($fell(settling) |-> run_r >= SETTLE_COUNT)
        else $error("settling too short");
    chk_settle_cause: assert property ($rose(settling) |-> $past(wr_sel) || $past(wr_sel, 2))
        else $error("settling without selection write");
    cov_settle: cover property ($fell(settling));
    cov_sample: cover property ($rose(sample_hold));
    cov_unmapped: cover property (acc && !mapped);
endmodule : aiss_sequencer_chk
`default_nettype wire

// [tb/aiss_sequencer_bench.sv]
// Bench: APB-driven scenarios for the selection sequencer with a SAR model
`timescale 1ns/1ps
`default_nettype none
module aiss_sequencer_bench;
    localparam int SETTLE = 20;
    logic ref_clk = 1'b0;
    logic rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic trigger_event = 1'b0;
    logic sleep_quiet = 1'b0;
    logic cpu_halted = 1'b0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [9:0] sar_code;
    aiss_pkg::aiss_sel_t active_sel;
    logic sample_hold;
    logic conv_irq_req;
    logic settling;
    int error_cnt = 0;
    int checks = 0;
    int cyc = 0;
    logic [31:0] rd;
    logic err;
    always #10 ref_clk = ~ref_clk;
    aiss_sequencer #(.SETTLE_COUNT(SETTLE)) u_aiss_sequencer (.ref_clk(ref_clk), .rst(rst), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .trigger_event(trigger_event), .sleep_quiet(sleep_quiet), .cpu_halted(cpu_halted),
        .sar_code(sar_code), .active_sel(active_sel), .sample_hold(sample_hold), .conv_irq_req(conv_irq_req),
        .settling(settling));
    aiss_sar_model u_aiss_sar_model (.ref_clk(ref_clk), .active_sel(active_sel), .sample_hold(sample_hold),
        .sar_code(sar_code));
    ////////////////////////////////////////////////////////////////////////////////
    function automatic logic [31:0] selw(input logic [6:0] s);
        return {24'h000000, s[6:5], 1'b0, s[4:0]};
    endfunction : selw
    function automatic logic [31:0] code(input logic [6:0] s);
        return {22'h000000, s[4:0], s[6:5], 3'h7};
    endfunction : code
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", name, exp, seen);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk);
        penable <= 1'b1;
        @(posedge ref_clk);
        while (pready !== 1'b1) @(posedge ref_clk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    // Waits for the completion request (0) or the sampling strobe (1)
    task automatic wait_sig(input int which);
        int n;
        n = 0;
        do begin
            @(posedge ref_clk);
            n++;
        end while ((which == 0 ? conv_irq_req : sample_hold) !== 1'b1 && n < 400);
    endtask : wait_sig
    task automatic conclude;
        $display("errors %0d checks %0d", error_cnt, checks);
        if (error_cnt == 0 && checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : conclude
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            error_cnt++;
            conclude();
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        logic [6:0] a;
        logic [6:0] b;
        int t;
        void'($urandom(32'h1A3CBA41));
        repeat (6) @(posedge ref_clk);
        rst <= 1'b0;
        apb(1'b0, 12'h000, 32'h0);
        chk("sel_reset", rd, 32'h0000_0000);
        apb(1'b0, 12'h010, 32'h0);
        chk("prescale_reset", rd, 32'h0000_0001);
        apb(1'b1, 12'h010, 32'h0000_00A5);
        apb(1'b0, 12'h010, 32'h0);
        chk("prescale_rw", rd, 32'h0000_00A5);
        apb(1'b1, 12'h010, 32'h0000_0001);
        apb(1'b1, 12'h014, 32'hFFFF_FFFF);
        chk("wr_unmapped_err", err, 1'b1);
        apb(1'b0, 12'h014, 32'h0);
        chk("rd_unmapped", rd, 32'h0000_0000);
        apb(1'b1, 12'h004, 32'h0000_0001);
        for (int r = 0; r < 4; r++) begin
            a = {2'(r), 5'($urandom())};
            apb(1'b1, 12'h000, selw(a));
            repeat (4) @(posedge ref_clk);
            chk("idle_copy", active_sel, a);
        end
        for (int h = 0; h < 2; h++) begin
            apb(1'b1, 12'h004, 32'h0000_0001 | (h << 3));
            while (settling === 1'b1) @(posedge ref_clk);
            a = active_sel ^ 7'h60;
            apb(1'b1, 12'h000, selw(a));
            t = 0;
            repeat (60) @(posedge ref_clk) t += (settling === 1'b1);
            chk("settle_len", t, SETTLE);
        end
        apb(1'b1, 12'h004, 32'h0000_0000);
        apb(1'b1, 12'h004, 32'h0000_0001);
        apb(1'b0, 12'h00C, 32'h0);
        chk("first_pending", rd[2:0], 3'h2);
        a = 7'($urandom());
        apb(1'b1, 12'h000, selw(a));
        repeat (4) @(posedge ref_clk);
        apb(1'b1, 12'h004, 32'h0000_0003);
        t = cyc;
        wait_sig(1);
        b = a ^ 7'h01;
        apb(1'b1, 12'h000, selw(b));
        chk("locked", active_sel, a);
        wait_sig(0);
        chk("first_len", (cyc - t) >= 50 && (cyc - t) <= 53, 1'b1);
        chk("resumed", active_sel, b);
        apb(1'b0, 12'h008, 32'h0);
        chk("result", rd, code(a));
        apb(1'b0, 12'h004, 32'h0);
        chk("ctrl_done", rd[5:0], 6'h11);
        apb(1'b1, 12'h004, 32'h0000_0011);
        apb(1'b1, 12'h004, 32'h0000_0003);
        t = cyc;
        wait_sig(0);
        chk("normal_len", (cyc - t) >= 26 && (cyc - t) <= 29, 1'b1);
        apb(1'b1, 12'h004, 32'h0000_0011);
        apb(1'b1, 12'h004, 32'h0000_0023);
        wait_sig(0);
        a = b ^ 7'h02;
        apb(1'b1, 12'h000, selw(a));
        apb(1'b1, 12'h004, 32'h0000_0033);
        wait_sig(0);
        apb(1'b0, 12'h008, 32'h0);
        chk("free_old", rd, code(b));
        apb(1'b1, 12'h004, 32'h0000_0033);
        wait_sig(0);
        apb(1'b0, 12'h008, 32'h0);
        chk("free_new", rd, code(a));
        apb(1'b1, 12'h004, 32'h0000_0011);
        wait_sig(0);
        apb(1'b1, 12'h004, 32'h0000_0010);
        a = 7'($urandom());
        apb(1'b1, 12'h000, selw(a));
        apb(1'b1, 12'h004, 32'h0000_0005);
        trigger_event <= 1'b1;
        wait_sig(0);
        trigger_event <= 1'b0;
        chk("auto_done", conv_irq_req, 1'b1);
        apb(1'b0, 12'h008, 32'h0);
        chk("auto_result", rd, code(a));
        apb(1'b1, 12'h004, 32'h0000_0011);
        sleep_quiet <= 1'b1;
        @(posedge ref_clk);
        cpu_halted <= 1'b1;
        wait_sig(1);
        chk("sleep_start", sample_hold, 1'b1);
        sleep_quiet <= 1'b0;
        cpu_halted <= 1'b0;
        wait_sig(0);
        chk("wake_irq", conv_irq_req, 1'b1);
        conclude();
    end
endmodule : aiss_sequencer_bench
bind aiss_sequencer aiss_sequencer_chk #(.SETTLE_COUNT(SETTLE_COUNT)) u_aiss_sequencer_chk (.ref_clk(ref_clk),
    .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .trigger_event(trigger_event), .sleep_quiet(sleep_quiet),
    .cpu_halted(cpu_halted), .sar_code(sar_code), .active_sel(active_sel), .sample_hold(sample_hold),
    .conv_irq_req(conv_irq_req), .settling(settling));
`default_nettype wire
